// file: verilog/nvs_pkg.sv
// constants shared by the store/recall sequencer
// assumes a single 20 MHz clock mclk and the async active-low reset rst_b
package nvs_pkg;
  localparam int CLK_MHZ          = 20;
  localparam int T_FA_MS          = 20;
  localparam int T_STORE_MS       = 8;
  localparam int T_RECALL_US      = 600;
  localparam int T_DELAY_NS       = 25;
  localparam int T_LZHSB_US       = 5;
  localparam int T_WAKE_MS        = 20;
  localparam int T_SLEEP_MS       = 8;
  localparam int T_SB_US          = 100;
  localparam int T_SS_US          = 500;
  // cycle counts; the shortest time rounds down, at least one cycle
  localparam int CYC_FA           = T_FA_MS * 1000 * CLK_MHZ;
  localparam int CYC_STORE        = T_STORE_MS * 1000 * CLK_MHZ;
  localparam int CYC_RECALL       = T_RECALL_US * CLK_MHZ;
  localparam int CYC_DELAY        = (T_DELAY_NS * CLK_MHZ / 1000) < 1 ? 1 : (T_DELAY_NS * CLK_MHZ / 1000);
  localparam int CYC_LZHSB        = T_LZHSB_US * CLK_MHZ;
  localparam int CYC_WAKE         = T_WAKE_MS * 1000 * CLK_MHZ;
  localparam int CYC_SLEEP        = T_SLEEP_MS * 1000 * CLK_MHZ;
  localparam int CYC_SB           = T_SB_US * CLK_MHZ;
  localparam int CYC_SS           = T_SS_US * CLK_MHZ;
  localparam int CNT_W            = 24;

  typedef enum logic [8:0] {
    ST_POWERUP = 9'h001,
    ST_IDLE    = 9'h002,
    ST_SEQ     = 9'h004,
    ST_HOLDW   = 9'h008,
    ST_STORE   = 9'h010,
    ST_RECALL  = 9'h020,
    ST_RELEASE = 9'h040,
    ST_SLEEPIN = 9'h080,
    ST_SLEEP   = 9'h100
  } nvs_state_type;

  typedef enum logic [1:0] {
    CMD_NONE   = 2'h0,
    CMD_STORE  = 2'h1,
    CMD_RECALL = 2'h2,
    CMD_SLEEP  = 2'h3
  } nvs_cmd_type;
endpackage

// file: verilog/nvs_timer.sv
// down-counting interval timer, loaded with a cycle count
// assumes the mclk domain; done is high while the count is zero
module nvs_timer #(
  parameter int W = 24
) (
  input  wire logic         mclk,
  input  wire logic         rst_b,
  input  wire logic         load,
  input  wire logic [W-1:0] count,
  output logic              done
);
  logic [W-1:0] cnt_reg;

  // load wins over counting
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_reg <= '0;
    end else if (load) begin
      cnt_reg <= count;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign done = (cnt_reg == '0);
endmodule

// file: verilog/nvs_seq.sv
// store/recall sequencer of a serial nonvolatile sram
// assumes synchronous inputs from the bus controller and supply monitor
module nvs_seq
  import nvs_pkg::*;
#(
  parameter int FA_CYC     = CYC_FA,
  parameter int STORE_CYC  = CYC_STORE,
  parameter int WAKE_CYC   = CYC_WAKE,
  parameter int SLEEP_CYC  = CYC_SLEEP,
  parameter int RECALL_CYC = CYC_RECALL,
  parameter int SS_CYC     = CYC_SS,
  parameter int SB_CYC     = CYC_SB,
  parameter int LZHSB_CYC  = CYC_LZHSB
) (
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        vcc_ok,
  input  wire logic        cmd_valid,
  input  wire nvs_pkg::nvs_cmd_type cmd_code,
  input  wire logic        wake_req,
  input  wire logic        bus_stop,
  input  wire logic        bus_active,
  input  wire logic        array_wr,
  input  wire logic        array_rd,
  input  wire logic        store_busy_pin_in,
  output logic             store_busy_pin_out,
  output logic             store_busy_pin_oe,
  output logic             array_wr_en,
  output logic             array_rd_en,
  output logic             serial_ready,
  output logic             nv_store_go,
  output logic             nv_recall_go,
  output logic             standby,
  output logic             low_power
);
  import nvs_pkg::*;

  nvs_state_type state_reg, state_next;
  nvs_cmd_type   cmd_reg;
  logic          pend_reg;
  logic          pin_req_reg;
  logic          pin_hold_reg;
  logic          vcc_prev_reg;
  logic          sb_arm_reg;
  logic          standby_reg;
  logic          tmr_load, tmr_done, sb_load, sb_done;
  logic [CNT_W-1:0] tmr_count;

  // power-fail edge and external pin pull-down
  wire pf_event    = vcc_prev_reg && !vcc_ok;
  wire pin_low     = !store_busy_pin_in && !store_busy_pin_oe;
  wire pin_store   = pin_low && !pin_hold_reg && (state_reg == ST_IDLE);
  wire auto_req    = pf_event || pin_store;
  wire store_need  = auto_req && pend_reg;
  wire busy_nv     = (state_reg == ST_STORE) || (state_reg == ST_RECALL);
  wire in_idle     = (state_reg == ST_IDLE);
  wire op_done     = busy_nv && tmr_done;
  // restore done; the cycle of the supply rise only loads the timer
  wire pu_done     = (state_reg == ST_POWERUP) && tmr_done && vcc_ok && vcc_prev_reg;

  // next state
  always_comb begin
    state_next = state_reg;
    tmr_load   = 1'b0;
    tmr_count  = '0;
    unique case (state_reg)
      ST_POWERUP: begin
        if (pu_done) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (store_need) begin
          state_next = ST_HOLDW;
          tmr_load   = 1'b1;
          tmr_count  = CNT_W'(CYC_DELAY - 1);                   // state lasts one cycle past the load
        end else if (cmd_valid && vcc_ok && cmd_code != CMD_NONE) begin
          state_next = ST_SEQ;
          tmr_load   = 1'b1;
          tmr_count  = CNT_W'(SS_CYC);
        end
      end
      ST_SEQ: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          unique case (cmd_reg)
            CMD_STORE: begin
              state_next = ST_STORE;
              tmr_count  = CNT_W'(STORE_CYC);
            end
            CMD_RECALL: begin
              state_next = ST_RECALL;
              tmr_count  = CNT_W'(RECALL_CYC);
            end
            CMD_SLEEP: begin
              state_next = ST_SLEEPIN;
              tmr_count  = CNT_W'(SLEEP_CYC);
            end
            CMD_NONE: begin
              state_next = ST_IDLE;
              tmr_load   = 1'b0;
            end
          endcase
        end
      end
      ST_HOLDW: begin
        if (tmr_done) begin
          state_next = ST_STORE;
          tmr_load   = 1'b1;
          tmr_count  = CNT_W'(STORE_CYC);
        end
      end
      ST_STORE, ST_RECALL: begin
        if (tmr_done) begin
          state_next = ST_RELEASE;
          tmr_load   = 1'b1;
          tmr_count  = CNT_W'(LZHSB_CYC);
        end
      end
      ST_RELEASE: begin
        if (tmr_done && !pin_low) begin
          state_next = ST_IDLE;
        end
      end
      ST_SLEEPIN: begin
        if (tmr_done) begin
          state_next = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (wake_req) begin
          state_next = ST_POWERUP;
          tmr_load   = 1'b1;
          tmr_count  = CNT_W'(WAKE_CYC);
        end
      end
    endcase
  end

  // state, command latch and the power-up timer start
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg    <= ST_POWERUP;
      cmd_reg      <= CMD_NONE;
      vcc_prev_reg <= 1'b0;
    end else begin
      state_reg    <= state_next;
      vcc_prev_reg <= vcc_ok;
      if (in_idle && cmd_valid) begin
        cmd_reg <= cmd_code;
      end
    end
  end

  // power-up recall window restarts when supply rises through the trip level
  wire vcc_rise  = vcc_ok && !vcc_prev_reg && (state_reg == ST_POWERUP);
  wire t_load    = tmr_load || vcc_rise;
  wire [CNT_W-1:0] t_count = vcc_rise ? CNT_W'(FA_CYC) : tmr_count;

  nvs_timer #(.W(CNT_W)) u_op_tmr (
    .mclk  (mclk),
    .rst_b (rst_b),
    .load  (t_load),
    .count (t_count),
    .done  (tmr_done)
  );

  // write-pending flag; a write in the completion cycle wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
    end else if (array_wr && array_wr_en) begin
      pend_reg <= 1'b1;
    end else if (op_done || pu_done) begin
      pend_reg <= 1'b0;
    end
  end

  // one pin request per low period of the pin
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_hold_reg <= 1'b0;
      pin_req_reg  <= 1'b0;
    end else begin
      pin_hold_reg <= pin_low;
      pin_req_reg  <= pin_store && !pend_reg;
    end
  end

  // standby timer after a stop
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sb_arm_reg  <= 1'b0;
      standby_reg <= 1'b0;
    end else begin
      if (bus_active || !in_idle) begin
        sb_arm_reg  <= 1'b0;
        standby_reg <= 1'b0;
      end else if (bus_stop) begin
        sb_arm_reg  <= 1'b1;
      end else if (sb_arm_reg && sb_done) begin
        sb_arm_reg  <= 1'b0;
        standby_reg <= 1'b1;
      end
    end
  end

  assign sb_load = bus_stop && in_idle;

  nvs_timer #(.W(CNT_W)) u_sb_tmr (
    .mclk  (mclk),
    .rst_b (rst_b),
    .load  (sb_load),
    .count (CNT_W'(SB_CYC)),
    .done  (sb_done)
  );

  // pin driver: low in ST_HOLDW, ST_STORE and ST_RECALL; not driven during the power-up recall in ST_POWERUP
  assign store_busy_pin_out = 1'b0;
  assign store_busy_pin_oe  = busy_nv || (state_reg == ST_HOLDW);

  // array and serial gating
  wire access_ok = vcc_ok && !busy_nv && !pin_low;
  assign array_wr_en  = (access_ok && (in_idle || state_reg == ST_SEQ)) || (state_reg == ST_HOLDW);
  assign array_rd_en  = access_ok && (in_idle || state_reg == ST_SEQ);
  assign serial_ready = access_ok && in_idle;
  assign nv_store_go  = (state_reg == ST_STORE);
  assign nv_recall_go = (state_reg == ST_RECALL) || (state_reg == ST_POWERUP);
  assign standby      = standby_reg;
  assign low_power    = (state_reg == ST_SLEEP);

  // cycles spent in the present state, for the interval bounds below
  logic [CNT_W-1:0] dwell_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      dwell_reg <= '0;
    end else if (state_next != state_reg) begin
      dwell_reg <= '0;
    end else begin
      dwell_reg <= dwell_reg + 1'b1;
    end
  end

  // cycles since the last stop while standby is armed
  logic [CNT_W-1:0] sb_wait_reg;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sb_wait_reg <= '0;
    end else if (!sb_arm_reg || bus_stop) begin
      sb_wait_reg <= '0;
    end else begin
      sb_wait_reg <= sb_wait_reg + 1'b1;
    end
  end

  // release bound: the hold time plus the cycle that leaves the state
  localparam int REL_MAX = LZHSB_CYC + 1;

  // assertions
  store_lock_a: assert property (@(posedge mclk) disable iff (!rst_b)
    busy_nv |-> !serial_ready && !array_wr_en) else $error("access during nv op");
  skip_store_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (in_idle && auto_req && !pend_reg) |=> state_reg != ST_HOLDW) else $error("needless store");
  hold_write_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (in_idle && store_need) |=> array_wr_en ##1 state_reg == ST_STORE) else $error("write hold wrong");
  low_vcc_a: assert property (@(posedge mclk) disable iff (!rst_b)
    !vcc_ok |-> !array_rd_en && !serial_ready) else $error("access at low supply");
  pin_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    pin_low |-> !array_rd_en && !serial_ready) else $error("array on with pin low");
  pin_off_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (in_idle || state_reg == ST_SLEEP) |-> !store_busy_pin_oe) else $error("pin driven idle");
  sleep_enter_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SLEEPIN) |-> dwell_reg <= CNT_W'(SLEEP_CYC)) else $error("sleep late");
  pend_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (array_wr && array_wr_en) |=> pend_reg) else $error("pending not set");
  release_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $fell(busy_nv) |-> state_reg == ST_RELEASE [*1] ##[1:REL_MAX] (in_idle || pin_low))
    else $error("release late");

  // interval bounds of the nonvolatile operations, and the power-up recall gating
  store_time_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_STORE) |-> dwell_reg <= CNT_W'(STORE_CYC)) else $error("store too long");
  recall_time_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_RECALL) |-> dwell_reg <= CNT_W'(RECALL_CYC)) else $error("recall too long");
  powerup_recall_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_POWERUP) |-> nv_recall_go && !serial_ready) else $error("access during restore");

  // stores started or skipped, and the pending flag
  pf_store_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (in_idle && pf_event && pend_reg) |=> state_reg == ST_HOLDW) else $error("power-fail store lost");
  pin_skip_a: assert property (@(posedge mclk) disable iff (!rst_b)
    pin_req_reg |-> !store_busy_pin_oe && !nv_store_go) else $error("skipped store driven");
  pend_clr_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (op_done && !(array_wr && array_wr_en)) |=> !pend_reg) else $error("pending not cleared");

  // commands, sleep, wake and standby
  seq_time_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SEQ) |-> dwell_reg <= CNT_W'(SS_CYC)) else $error("command late");
  cmd_taken_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (in_idle && !store_need && cmd_valid && vcc_ok && cmd_code != CMD_NONE) |=> state_reg == ST_SEQ)
    else $error("command dropped");
  wake_start_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (state_reg == ST_SLEEP && wake_req) |=> state_reg == ST_POWERUP && nv_recall_go) else $error("wake lost");
  sleep_shut_a: assert property (@(posedge mclk) disable iff (!rst_b)
    low_power |-> !serial_ready && !array_rd_en) else $error("access in sleep");
  standby_time_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sb_arm_reg |-> sb_wait_reg <= CNT_W'(SB_CYC)) else $error("standby late");
  standby_clr_a: assert property (@(posedge mclk) disable iff (!rst_b)
    bus_active |=> !standby) else $error("standby during transaction");
endmodule

// file: tb/nvs_bus_master.sv
// partner bus master: array accesses, commands, wake and bus transactions
// assumes the mclk domain; outputs change by nonblocking assignment at the rising edge
module nvs_bus_master
  import nvs_pkg::*;
(
  input  wire logic                 mclk,
  input  wire logic                 serial_ready,
  output logic                      cmd_valid,
  output nvs_pkg::nvs_cmd_type      cmd_code,
  output logic                      array_wr,
  output logic                      array_rd,
  output logic                      bus_stop,
  output logic                      bus_active,
  output logic                      wake_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {cmd_valid, array_wr, array_rd, bus_stop, bus_active, wake_req} = 6'h00;
    cmd_code = CMD_NONE;
  end
  // commands once the device reports ready again, or after 3000 cycles without it
  task automatic command(input nvs_cmd_type code);
    int n;
    n = 0;
    while (serial_ready !== 1'b1 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    @(posedge mclk);
    cmd_valid <= 1'b1;
    cmd_code  <= code;
    @(posedge mclk);
    cmd_valid <= 1'b0;
    cmd_code  <= CMD_NONE;
  endtask
  // one array write or read attempt
  task automatic access(input logic wr);
    @(posedge mclk);
    array_wr <= wr;
    array_rd <= ~wr;
    @(posedge mclk);
    {array_wr, array_rd} <= 2'h0;
  endtask
  task automatic wake();
    @(posedge mclk);
    wake_req <= 1'b1;
    @(posedge mclk);
    wake_req <= 1'b0;
  endtask
  // short transaction closed by a stop
  task automatic transaction();
    @(posedge mclk);
    bus_active <= 1'b1;
    repeat (3) @(posedge mclk);
    bus_active <= 1'b0;
    bus_stop   <= 1'b1;
    @(posedge mclk);
    bus_stop <= 1'b0;
  endtask
endmodule

// file: tb/nvs_seq_bench.sv
// bench for the store/recall sequencer, one task per scenario
// assumes the partner bus master model and shortened interval counts
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin mismatches++; \
  $display("ERROR t=%0t got %0h exp %0h", $time, (a), (e)); end end
module nvs_seq_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import nvs_pkg::*;
  localparam int FA = 20, ST = 30, WK = 20, SL = 15, RC = 25, SS = 10, SB = 12, LZ = 10;
  logic mclk, rst_b, vcc_ok, ext_low;
  int   mismatches, checks_done, cycles, n;
  wire logic cmd_valid, array_wr, array_rd, bus_stop, bus_active, wake_req;
  wire nvs_cmd_type cmd_code;
  wire logic pin_out, pin_oe, array_wr_en, array_rd_en, serial_ready;
  wire logic nv_store_go, nv_recall_go, standby, low_power;
  // weak pull-up unless a party pulls low
  wire logic pin = pin_oe ? pin_out : ~ext_low;
  wire [5:0] obs = {array_wr_en, serial_ready, nv_store_go, nv_recall_go, low_power, standby};
  nvs_seq #(.FA_CYC(FA), .STORE_CYC(ST), .WAKE_CYC(WK), .SLEEP_CYC(SL), .RECALL_CYC(RC),
            .SS_CYC(SS), .SB_CYC(SB), .LZHSB_CYC(LZ)) dut (
    .mclk(mclk), .rst_b(rst_b), .vcc_ok(vcc_ok), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .wake_req(wake_req), .bus_stop(bus_stop), .bus_active(bus_active), .array_wr(array_wr),
    .array_rd(array_rd), .store_busy_pin_in(pin), .store_busy_pin_out(pin_out),
    .store_busy_pin_oe(pin_oe), .array_wr_en(array_wr_en), .array_rd_en(array_rd_en),
    .serial_ready(serial_ready), .nv_store_go(nv_store_go), .nv_recall_go(nv_recall_go),
    .standby(standby), .low_power(low_power));
  nvs_bus_master bus (
    .mclk(mclk), .serial_ready(serial_ready), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .array_wr(array_wr), .array_rd(array_rd), .bus_stop(bus_stop), .bus_active(bus_active),
    .wake_req(wake_req));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // cycles until an observed output reaches a level, bounded
  task automatic wait_bit(input int b, input logic v, output int k);
    k = 0;
    do begin
      @(posedge mclk);
      #1;
      k++;
    end while (obs[b] !== v && k < 2000);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic t_powerup();
    @(posedge mclk) vcc_ok <= 1'b1;
    #1 `CHK(serial_ready, 1'b0)
    `CHK(nv_recall_go, 1'b1)
    wait_bit(4, 1'b1, n);
    `CHK(n >= FA && n <= FA + LZ + 4, 1'b1)
    $display("test powerup done");
  endtask
  // pin held low with nothing written: no store, driver off, array shut
  task automatic t_pin_skip();
    @(posedge mclk) ext_low <= 1'b1;
    repeat (3) @(posedge mclk);
    #1 `CHK(pin_oe, 1'b0)
    `CHK(nv_store_go, 1'b0)
    `CHK(array_wr_en, 1'b0)
    @(posedge mclk) ext_low <= 1'b0;
    wait_bit(4, 1'b1, n);
    `CHK(n <= LZ + 4, 1'b1)
    $display("test pin skip done");
  endtask
  task automatic t_cmd(input nvs_cmd_type code, input int b, input int dur);
    bus.access(1'b1);
    bus.command(code);
    wait_bit(b, 1'b1, n);
    `CHK(n <= SS + 4, 1'b1)
    bus.access(1'b0);
    #1 `CHK(serial_ready, 1'b0)
    `CHK({array_rd_en, array_wr_en}, 2'h0)
    wait_bit(b, 1'b0, n);
    `CHK(n + 3 >= dur - 2 && n <= dur + 2, 1'b1)
    wait_bit(4, 1'b1, n);
    `CHK(n <= LZ + 4, 1'b1)
    $display("test command %0d done", code);
  endtask
  task automatic t_pin_store();
    bus.access(1'b1);
    @(posedge mclk) ext_low <= 1'b1;
    @(posedge mclk) ext_low <= 1'b0;
    #1 `CHK({array_wr_en, pin_oe}, 2'h3)
    wait_bit(3, 1'b1, n);
    `CHK(n <= 4, 1'b1)
    repeat (2) @(posedge mclk);
    #1 `CHK(array_wr_en, 1'b0)
    `CHK({pin_oe, pin_out}, 2'h2)
    wait_bit(4, 1'b1, n);
    `CHK(n <= ST + LZ + 4, 1'b1)
    $display("test pin store done");
  endtask
  task automatic t_power_fail();
    bus.access(1'b1);
    @(posedge mclk) vcc_ok <= 1'b0;
    wait_bit(3, 1'b1, n);
    `CHK(n <= 4, 1'b1)
    bus.access(1'b0);
    #1 `CHK(array_rd_en, 1'b0)
    wait_bit(3, 1'b0, n);
    @(posedge mclk) vcc_ok <= 1'b1;
    wait_bit(4, 1'b1, n);
    `CHK(n <= FA + LZ + 4, 1'b1)
    $display("test power fail done");
  endtask
  task automatic t_sleep();
    bus.command(CMD_SLEEP);
    wait_bit(1, 1'b1, n);
    `CHK(n <= SS + SL + 4, 1'b1)
    `CHK(serial_ready, 1'b0)
    bus.wake();
    wait_bit(4, 1'b1, n);
    `CHK(n <= WK + LZ + 4, 1'b1)
    `CHK(low_power, 1'b0)
    $display("test sleep done");
  endtask
  task automatic t_standby();
    bus.transaction();
    #1 `CHK(standby, 1'b0)
    wait_bit(0, 1'b1, n);
    `CHK(n + 2 >= SB && n <= SB + 4, 1'b1)
    $display("test standby done");
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 8000) begin
      mismatches++;
      results();
    end
  end
  initial begin
    {mismatches, checks_done, cycles} = '0;
    {rst_b, vcc_ok, ext_low} = 3'h0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'b1;
    t_powerup();
    t_pin_skip();
    t_cmd(CMD_STORE, 3, ST);
    t_pin_skip();
    t_cmd(CMD_RECALL, 2, RC);
    t_pin_store();
    t_power_fail();
    t_sleep();
    t_standby();
    results();
  end
endmodule
